// >>> hw/sample_clock_routing.sv
// sample clock source selection, reference selection and clock export routing
`timescale 1ns/1ns
`include "sample_clock_routing_defs.svh"
// Summary of operation
// - sample clock from one selected source
// - strobe source only for acquisition operations
// - star line only for backplane, not slot 2
// - export to none, front jack or connector
// - codes 21 pass, 22 invert, 23 delay
// - delay is period fraction, delayed mode only
// - reference rate only 10 MHz, unless none
// - reference source none, front, backplane, line seven
// - rate always programmed; onboard rate reads coerced
module sample_clock_routing
    import sample_clock_routing_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire clk_pins_t pins,
    input wire logic is_backplane,
    input wire logic [4:0] slot_number,
    input wire logic op_is_acquisition,
    input wire logic gen_running,
    input wire logic acq_running,
    input wire logic cfg_write,
    input wire clk_cfg_t cfg_in,
    output logic cfg_ack,
    output logic cfg_reject,
    output err_t cfg_err_code,
    output clk_cfg_t active_cfg,
    output logic [31:0] rate_readback,
    output logic sample_clock,
    output logic front_clock_output,
    output logic connector_clock_output,
    output logic ref_in_use,
    output logic ref_clock
);
    clk_cfg_t active_ff;
    logic ack_ff;
    logic reject_ff;
    err_t err_ff;
    err_t nxt_err;
    logic sample_clk_ff;
    logic export_level;
    logic front_out_ff;
    logic conn_out_ff;
    logic ref_use_ff;
    logic ref_clk_ff;
    logic [31:0] rate_rb_ff;
    logic [31:0] nxt_rate_rb;

    // ************************************************************
    // configuration check
    // ************************************************************

    // refusal priority: busy first, then source, reference, and mode last
    function automatic err_t check_cfg(
        input clk_cfg_t c,
        input logic running,
        input logic acq,
        input logic backplane,
        input logic [4:0] slot
    );
        err_t e;
        e = ERR_NONE;
        if (running) begin
            e = ERR_BUSY;
        end else if (c.src == SRC_STROBE && !acq) begin
            e = ERR_STROBE;
        end else if (c.src == SRC_STAR && (!backplane || slot == `TIMING_SLOT)) begin
            e = ERR_STAR;
        end else if ((c.ref_src == REF_BACKPLANE && !backplane) ||
                     (c.ref_src == REF_SYNC_LINE_SEVEN && backplane)) begin
            e = ERR_REF_SRC;
        end else if (c.ref_src != REF_NONE && c.ref_rate != `REF_RATE_HZ) begin
            e = ERR_REF_RATE;
        end else if (c.mode != `EXP_PASS_CODE && c.mode != `EXP_INV_CODE &&
                     c.mode != `EXP_DELAY_CODE) begin
            e = ERR_MODE;
        end
        return e;
    endfunction

    // onboard oscillator snaps the request into its window and onto its grid
    function automatic logic [31:0] coerce_rate(input logic [31:0] r);
        logic [31:0] c;
        c = r;
        if (c < `OSC_MIN_HZ) begin
            c = `OSC_MIN_HZ;
        end else if (c > `OSC_MAX_HZ) begin
            c = `OSC_MAX_HZ;
        end
        return c & `OSC_GRID_MASK;
    endfunction

    always_comb begin
        nxt_err = check_cfg(cfg_in, gen_running | acq_running, op_is_acquisition,
                            is_backplane, slot_number);
    end

    // ************************************************************
    // write acceptance and active settings
    // ************************************************************

    // answers hold while ce is low, so a pulse may stretch over frozen cycles
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack_ff <= 1'b0;
            reject_ff <= 1'b0;
            err_ff <= ERR_NONE;
        end else if (ce) begin
            ack_ff <= cfg_write && (nxt_err == ERR_NONE);
            reject_ff <= cfg_write && (nxt_err != ERR_NONE);
            if (cfg_write) begin
                err_ff <= nxt_err;
            end
        end
    end

    // a refused write leaves every setting untouched, so no clock glitches mid-run
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            active_ff.src <= SRC_INTERNAL;
            active_ff.dest <= DEST_NONE;
            active_ff.mode <= `EXP_PASS_CODE;
            active_ff.delay_frac <= `FRAC_ZERO;
            active_ff.ref_src <= REF_NONE;
            active_ff.ref_rate <= `REF_RATE_HZ;
            active_ff.rate <= `RATE_RESET_HZ;
        end else if (ce && cfg_write && nxt_err == ERR_NONE) begin
            active_ff <= cfg_in;
        end
    end

    // ************************************************************
    // sample clock and reference selection
    // ************************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sample_clk_ff <= 1'b0;
        end else if (ce) begin
            unique case (active_ff.src)
                SRC_INTERNAL: sample_clk_ff <= pins.internal_osc_source;
                SRC_FRONT: sample_clk_ff <= pins.front_clock_input;
                SRC_STAR: sample_clk_ff <= pins.star_line;
                SRC_STROBE: sample_clk_ff <= pins.strobe_line;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ref_clk_ff <= 1'b0;
            ref_use_ff <= 1'b0;
        end else if (ce) begin
            ref_use_ff <= (active_ff.ref_src != REF_NONE);
            unique case (active_ff.ref_src)
                REF_NONE: ref_clk_ff <= 1'b0;
                REF_FRONT: ref_clk_ff <= pins.front_clock_input;
                REF_BACKPLANE: ref_clk_ff <= pins.backplane_ref;
                REF_SYNC_LINE_SEVEN: ref_clk_ff <= pins.sync_bus_line_seven;
            endcase
        end
    end

    // ************************************************************
    // rate readback
    // ************************************************************

    // external sources keep the programmed figure; it still feeds software checks
    always_comb begin
        nxt_rate_rb = (active_ff.src == SRC_INTERNAL) ? coerce_rate(active_ff.rate) : active_ff.rate;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            // reset source is the onboard oscillator, so even the reset figure is a coerced one
            rate_rb_ff <= `OSC_MAX_HZ & `OSC_GRID_MASK;
        end else if (ce) begin
            rate_rb_ff <= nxt_rate_rb;
        end
    end

    // ************************************************************
    // export shaping and routing
    // ************************************************************
    export_phase_shaper u_shaper (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .clk_in(sample_clk_ff),
        .mode(active_ff.mode),
        .delay_frac(active_ff.delay_frac),
        .clk_out(export_level)
    );

    // unselected destinations sit low rather than floating
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            front_out_ff <= 1'b0;
            conn_out_ff <= 1'b0;
        end else if (ce) begin
            front_out_ff <= (active_ff.dest == DEST_FRONT) && export_level;
            conn_out_ff <= (active_ff.dest == DEST_CONNECTOR) && export_level;
        end
    end

    assign cfg_ack = ack_ff;
    assign cfg_reject = reject_ff;
    assign cfg_err_code = err_ff;
    assign active_cfg = active_ff;
    assign rate_readback = rate_rb_ff;
    assign sample_clock = sample_clk_ff;
    assign front_clock_output = front_out_ff;
    assign connector_clock_output = conn_out_ff;
    assign ref_in_use = ref_use_ff;
    assign ref_clock = ref_clk_ff;

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_write_idle;
        ce && cfg_write && !gen_running && !acq_running;
    endsequence

    sequence s_refused(err_t code);
        cfg_reject && !cfg_ack && cfg_err_code == code;
    endsequence

    a_busy_refuse: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && cfg_write && (gen_running || acq_running)) |=> (s_refused(ERR_BUSY) and $stable(active_cfg)))
        else $error("write taken while an operation runs");

    a_strobe_gen: assert property (@(posedge clk_sys) disable iff (rst)
        (s_write_idle and (cfg_in.src == SRC_STROBE && !op_is_acquisition)) |=> s_refused(ERR_STROBE))
        else $error("strobe source taken for generation");

    a_star_slot: assert property (@(posedge clk_sys) disable iff (rst)
        (s_write_idle and (cfg_in.src == SRC_STAR && slot_number == `TIMING_SLOT)) |=> s_refused(ERR_STAR))
        else $error("star source taken in timing slot");

    a_ref_card: assert property (@(posedge clk_sys) disable iff (rst)
        (s_write_idle and (cfg_in.src inside {SRC_INTERNAL, SRC_FRONT} &&
         cfg_in.ref_src == REF_BACKPLANE && !is_backplane))
        |=> s_refused(ERR_REF_SRC))
        else $error("backplane reference taken on a card unit");

    a_ref_rate: assert property (@(posedge clk_sys) disable iff (rst)
        (s_write_idle and (cfg_in.src inside {SRC_INTERNAL, SRC_FRONT} && cfg_in.ref_src == REF_FRONT &&
         cfg_in.ref_rate != `REF_RATE_HZ)) |=> s_refused(ERR_REF_RATE))
        else $error("reference rate other than 10 MHz taken");

    a_ref_none_ok: assert property (@(posedge clk_sys) disable iff (rst)
        (s_write_idle and (cfg_in.src inside {SRC_INTERNAL, SRC_FRONT} && cfg_in.ref_src == REF_NONE &&
         cfg_in.mode inside {`EXP_PASS_CODE, `EXP_INV_CODE, `EXP_DELAY_CODE}))
        |=> (cfg_ack ##1 (!$past(ce) || !ref_in_use)))
        else $error("reference rate not ignored with no reference");

    a_apply_cfg: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && cfg_write && nxt_err == ERR_NONE) |=> (cfg_ack && active_cfg == $past(cfg_in)))
        else $error("accepted settings not applied");

    a_source_follow: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && active_cfg.src == SRC_FRONT) |=> (sample_clock == $past(pins.front_clock_input)))
        else $error("sample clock does not follow the front input");

    a_route_off: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && active_cfg.dest == DEST_NONE) |=> (!front_clock_output && !connector_clock_output))
        else $error("clock exported with no destination");

    a_rate_coerce: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && active_cfg.src == SRC_INTERNAL) |=>
        (rate_readback >= (`OSC_MIN_HZ & `OSC_GRID_MASK) && rate_readback <= `OSC_MAX_HZ))
        else $error("onboard rate readback not coerced");
endmodule

// >>> hw/sample_clock_routing_defs.svh
// constants for the sample clock selection and export block
`ifndef SAMPLE_CLOCK_ROUTING_DEFS_SVH
`define SAMPLE_CLOCK_ROUTING_DEFS_SVH

// exported clock phase mode codes
`define EXP_PASS_CODE 8'h15
`define EXP_INV_CODE 8'h16
`define EXP_DELAY_CODE 8'h17

// the only reference clock rate accepted, in hertz (10 MHz)
`define REF_RATE_HZ 32'h0098_9680

// chassis slot that carries the system timing role
`define TIMING_SLOT 5'h02

// onboard oscillator coercion window and grid, in hertz
`define OSC_MIN_HZ 32'h000f_4240
`define OSC_MAX_HZ 32'h0beb_c200
`define OSC_GRID_MASK 32'hffff_fc00
`define RATE_RESET_HZ 32'h0beb_c200

// export delay line geometry
`define HIST_DEPTH 64
`define TAP_MAX 6'h3f
`define PERIOD_SAT 8'hff
`define PERIOD_ONE 8'h01
`define FRAC_ZERO 8'h00

`endif

// >>> hw/sample_clock_routing_pkg.sv
// types shared by the sample clock selection and export block
package sample_clock_routing_pkg;
`include "sample_clock_routing_defs.svh"

    typedef enum logic [1:0] {
        SRC_INTERNAL = 2'h0,
        SRC_FRONT = 2'h1,
        SRC_STAR = 2'h2,
        SRC_STROBE = 2'h3
    } clk_src_t;

    typedef enum logic [1:0] {
        DEST_NONE = 2'h0,
        DEST_FRONT = 2'h1,
        DEST_CONNECTOR = 2'h2
    } export_dest_t;

    typedef enum logic [1:0] {
        REF_NONE = 2'h0,
        REF_FRONT = 2'h1,
        REF_BACKPLANE = 2'h2,
        REF_SYNC_LINE_SEVEN = 2'h3
    } ref_src_t;

    typedef enum logic [2:0] {
        ERR_NONE = 3'h0,
        ERR_BUSY = 3'h1,
        ERR_STROBE = 3'h2,
        ERR_STAR = 3'h3,
        ERR_REF_SRC = 3'h4,
        ERR_REF_RATE = 3'h5,
        ERR_MODE = 3'h6
    } err_t;

    typedef struct packed {
        clk_src_t src;
        export_dest_t dest;
        logic [7:0] mode;
        logic [7:0] delay_frac;
        ref_src_t ref_src;
        logic [31:0] ref_rate;
        logic [31:0] rate;
    } clk_cfg_t;

    typedef struct packed {
        logic internal_osc_source;
        logic front_clock_input;
        logic star_line;
        logic strobe_line;
        logic backplane_ref;
        logic sync_bus_line_seven;
    } clk_pins_t;
endpackage

// >>> hw/export_phase_shaper.sv
// phase shaper for the exported sample clock: pass, invert or delay
`timescale 1ns/1ns
`include "sample_clock_routing_defs.svh"
module export_phase_shaper
    import sample_clock_routing_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic clk_in,
    input wire logic [7:0] mode,
    input wire logic [7:0] delay_frac,
    output logic clk_out
);
    logic hist_ff [0:`HIST_DEPTH-1];
    logic prev_ff;
    logic [7:0] cnt_ff;
    logic [7:0] period_ff;
    logic [15:0] scaled;
    logic [5:0] tap;
    logic clk_out_ff;

    // ************************************************************
    // period measurement in system clock cycles
    // ************************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prev_ff <= 1'b0;
            cnt_ff <= `PERIOD_ONE;
            period_ff <= `PERIOD_ONE;
        end else if (ce) begin
            prev_ff <= clk_in;
            if (clk_in && !prev_ff) begin
                period_ff <= cnt_ff;
                cnt_ff <= `PERIOD_ONE;
            end else if (cnt_ff != `PERIOD_SAT) begin
                cnt_ff <= cnt_ff + `PERIOD_ONE;
            end
        end
    end

    // ************************************************************
    // history line, tapped at the programmed fraction of a period
    // ************************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hist_ff[0] <= 1'b0;
        end else if (ce) begin
            hist_ff[0] <= clk_in;
        end
    end

    for (genvar i = 1; i < `HIST_DEPTH; i++) begin : g_hist
        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                hist_ff[i] <= 1'b0;
            end else if (ce) begin
                hist_ff[i] <= hist_ff[i-1];
            end
        end
    end

    // fraction is in 1/256 of a period; slow clocks saturate the tap, which is why the
    // delayed mode is only meaningful at higher sample rates
    assign scaled = period_ff * delay_frac;
    assign tap = (scaled[15:8] > {2'h0, `TAP_MAX}) ? `TAP_MAX : scaled[13:8];

    // ************************************************************
    // output mode select
    // ************************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clk_out_ff <= 1'b0;
        end else if (ce) begin
            unique case (mode)
                `EXP_PASS_CODE: clk_out_ff <= clk_in;
                `EXP_INV_CODE: clk_out_ff <= ~clk_in;
                `EXP_DELAY_CODE: clk_out_ff <= hist_ff[tap];
                default: clk_out_ff <= clk_in;
            endcase
        end
    end

    assign clk_out = clk_out_ff;

    a_invert_follow: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && mode == `EXP_INV_CODE) |=> (clk_out == !$past(clk_in)))
        else $error("inverted export does not follow the sample clock");

    a_delay_ignored: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && mode == `EXP_PASS_CODE && delay_frac != `FRAC_ZERO) |=> (clk_out == $past(clk_in)))
        else $error("delay applied outside the delayed mode");
endmodule

// >>> tb/clock_source_model.sv
// free-running clock sources seen at the block's source and reference pins
`timescale 1ns/1ns
module clock_source_model
    import sample_clock_routing_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    output clk_pins_t pins
);
    logic [7:0] div_ff;

    // ******************************
    // one divider feeds every source
    // ******************************
    // distinct periods let the bench tell the selected source apart;
    // the pins change just after the rising edge, like a real far side
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_ff <= 8'h00;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end

    // oscillators run free, so no idle level applies between operations
    assign pins.internal_osc_source = div_ff[1];
    assign pins.front_clock_input = div_ff[2];
    assign pins.star_line = div_ff[0];
    assign pins.strobe_line = div_ff[3];
    assign pins.backplane_ref = div_ff[4];
    assign pins.sync_bus_line_seven = div_ff[5];
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the sample clock selection and export block
`timescale 1ns/1ns
module tb_top
    import sample_clock_routing_pkg::*;
;
    typedef struct {clk_cfg_t c; logic bp; logic [4:0] slot; logic acq; logic gen; logic acr; err_t e;} row_t;
    localparam logic [31:0] ten_mhz = 32'h0098_9680;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    clk_pins_t pins;
    logic is_backplane = 1'b0;
    logic [4:0] slot_number = 5'h01;
    logic op_is_acquisition = 1'b0;
    logic gen_running = 1'b0;
    logic acq_running = 1'b0;
    logic cfg_write = 1'b0;
    clk_cfg_t cfg_in = '0;
    logic cfg_ack, cfg_reject, sample_clock, front_clock_output, connector_clock_output, ref_in_use, ref_clock;
    err_t cfg_err_code;
    clk_cfg_t active_cfg, exp_cfg, rst_cfg;
    logic [31:0] rate_readback, exp_rb;
    int n_errors = 0;
    int compares = 0;
    row_t q[$];

    always #2 clk_sys = ~clk_sys;

    clock_source_model src_u (.clk_sys(clk_sys), .rst(rst), .pins(pins));

    sample_clock_routing dut_u (.clk_sys(clk_sys), .rst(rst), .ce(ce), .pins(pins), .is_backplane(is_backplane),
        .slot_number(slot_number), .op_is_acquisition(op_is_acquisition), .gen_running(gen_running),
        .acq_running(acq_running), .cfg_write(cfg_write), .cfg_in(cfg_in), .cfg_ack(cfg_ack),
        .cfg_reject(cfg_reject), .cfg_err_code(cfg_err_code), .active_cfg(active_cfg),
        .rate_readback(rate_readback), .sample_clock(sample_clock), .front_clock_output(front_clock_output),
        .connector_clock_output(connector_clock_output), .ref_in_use(ref_in_use), .ref_clock(ref_clock));

    // ******************************
    // helpers
    // ******************************
    function automatic clk_cfg_t mk(clk_src_t s, export_dest_t d, logic [7:0] m, logic [7:0] f, ref_src_t r,
                                    logic [31:0] rr, logic [31:0] rt);
        return '{s, d, m, f, r, rr, rt};
    endfunction

    function automatic row_t rw(clk_cfg_t c, logic bp, logic [4:0] sl, logic acq, logic gen, logic acr, err_t e);
        return '{c, bp, sl, acq, gen, acr, e};
    endfunction

    // oscillator rate is clamped to its range, then snapped to a 1024 Hz grid
    function automatic logic [31:0] coerce(logic [31:0] r);
        logic [31:0] c;
        c = (r < 32'h000f_4240) ? 32'h000f_4240 : ((r > 32'h0beb_c200) ? 32'h0beb_c200 : r);
        return c & 32'hffff_fc00;
    endfunction

    function automatic logic pin_of(clk_src_t s);
        case (s)
            SRC_INTERNAL: return pins.internal_osc_source;
            SRC_FRONT: return pins.front_clock_input;
            SRC_STAR: return pins.star_line;
            default: return pins.strobe_line;
        endcase
    endfunction

    function automatic logic ref_of(ref_src_t r);
        case (r)
            REF_FRONT: return pins.front_clock_input;
            REF_BACKPLANE: return pins.backplane_ref;
            REF_SYNC_LINE_SEVEN: return pins.sync_bus_line_seven;
            default: return 1'b0;
        endcase
    endfunction

    task automatic chk(string nm, logic [85:0] seen, logic [85:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // one write, held a single cycle; the answer stands one cycle only
    task automatic wr(row_t w);
        @(negedge clk_sys);
        cfg_in = w.c;
        cfg_write = 1'b1;
        is_backplane = w.bp;
        slot_number = w.slot;
        op_is_acquisition = w.acq;
        gen_running = w.gen;
        acq_running = w.acr;
        @(negedge clk_sys);
        cfg_write = 1'b0;
        gen_running = 1'b0;
        acq_running = 1'b0;
        if (w.e == ERR_NONE) begin
            exp_cfg = w.c;
            exp_rb = (w.c.src == SRC_INTERNAL) ? coerce(w.c.rate) : w.c.rate;
        end
        chk("cfg_ack", cfg_ack, w.e == ERR_NONE);
        chk("cfg_reject", cfg_reject, w.e != ERR_NONE);
        chk("cfg_err_code", cfg_err_code, w.e);
        chk("active_cfg", active_cfg, exp_cfg);
        @(negedge clk_sys);
        chk("ack_drop", cfg_ack | cfg_reject, 1'b0);
        chk("rate_readback", rate_readback, exp_rb);
        chk("ref_in_use", ref_in_use, exp_cfg.ref_src != REF_NONE);
    endtask

    // watch the selected source, the exported clock and the reference for a while
    task automatic watch(logic inv, int lag);
        logic [7:0] h, p, r;
        logic e;
        h = 8'h00;
        p = 8'h00;
        r = 8'h00;
        for (int i = 0; i < 40; i++) begin
            @(negedge clk_sys);
            h = {h[6:0], sample_clock};
            p = {p[6:0], pin_of(exp_cfg.src)};
            r = {r[6:0], ref_of(exp_cfg.ref_src)};
            e = h[lag] ^ inv;
            if (i >= 14) begin
                chk("sample_clock", sample_clock, p[1]);
                chk("front_out", front_clock_output, exp_cfg.dest == DEST_FRONT ? e : 1'b0);
                chk("conn_out", connector_clock_output, exp_cfg.dest == DEST_CONNECTOR ? e : 1'b0);
                chk("ref_clock", ref_clock, r[1]);
            end
        end
    endtask

    // ******************************
    // main sequence
    // ******************************
    initial begin
        rst_cfg = mk(SRC_INTERNAL, DEST_NONE, 8'h15, 8'h00, REF_NONE, ten_mhz, 32'h0beb_c200);
        exp_cfg = rst_cfg;
        exp_rb = coerce(32'h0beb_c200);
        // rate is always programmed, also for external sources
        q.push_back(rw(mk(SRC_INTERNAL, DEST_FRONT, 8'h15, 8'h00, REF_NONE, ten_mhz, 32'h05f5_e100),
            0, 5'h01, 0, 0, 0, ERR_NONE));
        q.push_back(rw(mk(SRC_INTERNAL, DEST_NONE, 8'h15, 8'h00, REF_NONE, ten_mhz, 32'h0007_a120),
            0, 5'h01, 0, 0, 0, ERR_NONE));
        q.push_back(rw(mk(SRC_INTERNAL, DEST_NONE, 8'h15, 8'h00, REF_NONE, ten_mhz, 32'h11e1_a300),
            0, 5'h01, 0, 0, 0, ERR_NONE));
        q.push_back(rw(mk(SRC_STROBE, DEST_NONE, 8'h15, 8'h00, REF_NONE, ten_mhz, 32'h02fa_f080),
            0, 5'h01, 0, 0, 0, ERR_STROBE));
        q.push_back(rw(mk(SRC_STROBE, DEST_NONE, 8'h15, 8'h00, REF_NONE, ten_mhz, 32'h02fa_f080),
            0, 5'h01, 1, 0, 0, ERR_NONE));
        q.push_back(rw(mk(SRC_STAR, DEST_NONE, 8'h15, 8'h00, REF_NONE, ten_mhz, 32'h02fa_f080),
            1, 5'h02, 0, 0, 0, ERR_STAR));
        q.push_back(rw(mk(SRC_STAR, DEST_NONE, 8'h15, 8'h00, REF_NONE, ten_mhz, 32'h02fa_f080),
            0, 5'h05, 0, 0, 0, ERR_STAR));
        q.push_back(rw(mk(SRC_STAR, DEST_NONE, 8'h15, 8'h00, REF_NONE, ten_mhz, 32'h02fa_f080),
            1, 5'h03, 0, 0, 0, ERR_NONE));
        q.push_back(rw(mk(SRC_FRONT, DEST_NONE, 8'h15, 8'h00, REF_BACKPLANE, ten_mhz, 32'h02fa_f080),
            0, 5'h01, 0, 0, 0, ERR_REF_SRC));
        q.push_back(rw(mk(SRC_FRONT, DEST_NONE, 8'h15, 8'h00, REF_SYNC_LINE_SEVEN, ten_mhz, 32'h02fa_f080),
            1, 5'h04, 0, 0, 0, ERR_REF_SRC));
        q.push_back(rw(mk(SRC_FRONT, DEST_NONE, 8'h15, 8'h00, REF_FRONT, 32'h0098_967f, 32'h02fa_f080),
            0, 5'h01, 0, 0, 0, ERR_REF_RATE));
        q.push_back(rw(mk(SRC_FRONT, DEST_NONE, 8'h15, 8'h00, REF_NONE, 32'h0000_0005, 32'h02fa_f080),
            0, 5'h01, 0, 0, 0, ERR_NONE));
        q.push_back(rw(mk(SRC_FRONT, DEST_NONE, 8'h14, 8'h00, REF_NONE, ten_mhz, 32'h02fa_f080),
            0, 5'h01, 0, 0, 0, ERR_MODE));
        q.push_back(rw(mk(SRC_FRONT, DEST_NONE, 8'h18, 8'h00, REF_NONE, ten_mhz, 32'h02fa_f080),
            0, 5'h01, 0, 0, 0, ERR_MODE));
        q.push_back(rw(mk(SRC_INTERNAL, DEST_FRONT, 8'h16, 8'h00, REF_NONE, ten_mhz, 32'h02fa_f080),
            0, 5'h01, 0, 1, 0, ERR_BUSY));
        q.push_back(rw(mk(SRC_INTERNAL, DEST_FRONT, 8'h18, 8'h00, REF_NONE, ten_mhz, 32'h02fa_f080),
            0, 5'h01, 1, 0, 1, ERR_BUSY));
        q.push_back(rw(mk(SRC_FRONT, DEST_CONNECTOR, 8'h16, 8'h00, REF_BACKPLANE, ten_mhz, 32'h02fa_f080),
            1, 5'h04, 0, 0, 0, ERR_NONE));
        q.push_back(rw(mk(SRC_INTERNAL, DEST_FRONT, 8'h15, 8'h00, REF_SYNC_LINE_SEVEN, ten_mhz, 32'h02fa_f080),
            0, 5'h01, 0, 0, 0, ERR_NONE));
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("reset_ack", cfg_ack | cfg_reject | sample_clock | front_clock_output, 1'b0);
        chk("reset_cfg", active_cfg, rst_cfg);
        rst = 1'b0;
        @(negedge clk_sys);
        chk("reset_rate", rate_readback, exp_rb);
        foreach (q[i]) begin
            wr(q[i]);
        end
        // pass mode ignores a programmed delay
        wr(rw(mk(SRC_INTERNAL, DEST_FRONT, 8'h15, 8'h80, REF_FRONT, ten_mhz, 32'h05f5_e100),
            0, 5'h01, 0, 0, 0, ERR_NONE));
        watch(1'b0, 2);
        wr(rw(mk(SRC_FRONT, DEST_CONNECTOR, 8'h16, 8'h00, REF_NONE, ten_mhz, 32'h05f5_e100),
            0, 5'h01, 0, 0, 0, ERR_NONE));
        watch(1'b1, 2);
        // delayed mode only at rates of 25 MS/s and up
        wr(rw(mk(SRC_INTERNAL, DEST_FRONT, 8'h17, 8'h80, REF_BACKPLANE, ten_mhz, 32'h02fa_f080),
            1, 5'h06, 0, 0, 0, ERR_NONE));
        watch(1'b0, 5);
        wr(rw(mk(SRC_STROBE, DEST_NONE, 8'h15, 8'h00, REF_SYNC_LINE_SEVEN, ten_mhz, 32'h05f5_e100),
            0, 5'h01, 1, 0, 0, ERR_NONE));
        watch(1'b0, 2);
        wr(rw(mk(SRC_STAR, DEST_FRONT, 8'h15, 8'h00, REF_NONE, ten_mhz, 32'h05f5_e100),
            1, 5'h07, 0, 0, 0, ERR_NONE));
        watch(1'b0, 2);
        // a write with the clock enable low must not be taken
        @(negedge clk_sys);
        ce = 1'b0;
        cfg_in = rst_cfg;
        cfg_write = 1'b1;
        @(negedge clk_sys);
        cfg_write = 1'b0;
        ce = 1'b1;
        @(negedge clk_sys);
        chk("ce_low_cfg", active_cfg, exp_cfg);
        // reset in mid-run returns to the power-up settings
        rst = 1'b1;
        @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        chk("rerst_cfg", active_cfg, rst_cfg);
        chk("rerst_rate", rate_readback, coerce(32'h0beb_c200));
        complete_run;
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        $display("[ERR] watchdog expected end seen hang");
        complete_run;
    end
endmodule
